// >>> inc/reset_cause_regs.svh
// reset-cause flag register constants: offsets, bit positions, reset values
// assumes inclusion by the reset-cause design files and test bench only
//
// Operation
// - stack overflow reset sets bit 7; zero at power-up; firmware may clear
// - stack underflow reset sets bit 6; zero at power-up; firmware may clear
// - watchdog reset clears bit 4; one at power-up; firmware may set
// - external pin reset clears bit 3; one at power-up; firmware may set
// - reset instruction clears bit 2; one at power-up; firmware may set
// - power-on reset clears bit 1; software then writes it to one
// - bit 5 holds nothing, reads zero, ignores writes
`ifndef RESET_CAUSE_REGS_SVH
`define RESET_CAUSE_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RC_OFS_FLAGS 8'h00
`define RC_OFS_EVT_STATUS 8'h04
`define RC_OFS_EVT_MASK 8'h08
`define RC_ADDR_W 8

// ----------------------------------------------------------------------------
// flag bit positions
// ----------------------------------------------------------------------------
`define RC_BIT_BROWNOUT 0
`define RC_BIT_POWERON 1
`define RC_BIT_INSTR 2
`define RC_BIT_PIN 3
`define RC_BIT_WDOG 4
`define RC_BIT_UNUSED 5
`define RC_BIT_STK_UNDER 6
`define RC_BIT_STK_OVER 7

// ----------------------------------------------------------------------------
// values
// ----------------------------------------------------------------------------
`define RC_FLAGS_POR 8'h1C
`define RC_FLAGS_IMPL 8'hDF
`define RC_EVT_NONE 8'h00
`define RC_HTRANS_NONSEQ 2'h2

`endif

// >>> inc/reset_cause_pkg.sv
// reset-cause types shared by the register and flag logic
// assumes the constants header is included alongside
package reset_cause_pkg;

    // one-cycle reset-source events, one per flag position
    typedef struct packed {
        logic stk_over;
        logic stk_under;
        logic unused;
        logic wdog;
        logic pin;
        logic instr;
        logic poweron;
        logic brownout;
    } reset_evt_t;

    // a captured ahb write
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
    } bus_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01
    } bus_state_t;

endpackage

// >>> logic/reset_flag_bit.sv
// one reset-cause flag bit: hardware event forces a level, firmware writes
// assumes events and writes are synchronous to clk_i
`timescale 1ns/1ps
module reset_flag_bit #(
    parameter logic RESET_VAL = 1'b0,
    parameter logic EVT_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic evt_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic flag_o
);

    // ------------------------------------------------------------------------
    // flag storage
    // ------------------------------------------------------------------------
    logic next_flag;

    // hardware event wins over a firmware write in the same cycle
    assign next_flag = evt_i ? EVT_VAL : (wr_i ? wdata_i : flag_o);

    // flag register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_o <= RESET_VAL;
        end else begin
            flag_o <= next_flag;
        end
    end

endmodule // reset_flag_bit

// >>> logic/reset_cause_wdata.sv
// ahb-lite write capture: holds the address phase for the data phase
// assumes a single slave whose hreadyout is the bus hready
`timescale 1ns/1ps
`include "reset_cause_regs.svh"
module reset_cause_wdata (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [7:0] haddr_i,
    output reset_cause_pkg::bus_wr_t wr_o
);

    // ------------------------------------------------------------------------
    // address phase decode
    // ------------------------------------------------------------------------
    logic take_wr;
    reset_cause_pkg::bus_state_t state;
    reset_cause_pkg::bus_state_t next_state;
    logic [7:0] wr_addr;

    assign take_wr = hsel_i && hready_i && hwrite_i && (htrans_i == `RC_HTRANS_NONSEQ);
    assign next_state = take_wr ? reset_cause_pkg::ST_WRITE : reset_cause_pkg::ST_IDLE;

    // capture write address for the data phase
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= reset_cause_pkg::ST_IDLE;
            wr_addr <= '0;
        end else begin
            state <= next_state;
            wr_addr <= take_wr ? haddr_i : wr_addr;
        end
    end

    // the write is live for exactly the data phase that follows its address phase
    assign wr_o = {state == reset_cause_pkg::ST_WRITE, wr_addr};

endmodule // reset_cause_wdata

// >>> logic/reset_cause_flags.sv
// reset-cause flag register with ahb-lite slave and event interrupt
// assumes reset-source events are one-cycle pulses synchronous to clk_i
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "reset_cause_regs.svh"
module reset_cause_flags (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire reset_cause_pkg::reset_evt_t evt_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic irq_o
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    reset_cause_pkg::bus_wr_t wr;
    reset_cause_pkg::reset_evt_t evt_eff;
    logic [7:0] flags;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic [7:0] evt_vec;
    logic [7:0] next_status;
    logic [7:0] rd_mux;
    logic wr_flags;
    logic wr_status;
    logic wr_mask;
    logic take_rd;
    logic [7:0] hit_ofs;

    // power-up flag pattern, indexed per bit by the generate loop
    localparam logic [7:0] POR_FLAGS = `RC_FLAGS_POR;

    // ------------------------------------------------------------------------
    // write capture
    // ------------------------------------------------------------------------
    reset_cause_wdata u_wdata (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .hsel_i(hsel_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .haddr_i(haddr_i[7:0]),
        .wr_o(wr)
    );

    // register select decode
    assign wr_flags = wr.valid && (wr.addr == `RC_OFS_FLAGS);
    assign wr_status = wr.valid && (wr.addr == `RC_OFS_EVT_STATUS);
    assign wr_mask = wr.valid && (wr.addr == `RC_OFS_EVT_MASK);
    assign take_rd = hsel_i && hready_i && !hwrite_i && (htrans_i == `RC_HTRANS_NONSEQ);
    assign hit_ofs = haddr_i[7:0];

    // ------------------------------------------------------------------------
    // event shaping
    // ------------------------------------------------------------------------
    // a power-on reset also clears the brown-out flag
    always_comb begin
        evt_eff = evt_i;
        evt_eff.unused = 1'b0;
        evt_eff.brownout = evt_i.brownout | evt_i.poweron;
    end

    // ------------------------------------------------------------------------
    // flag bits: one instance per implemented position
    // ------------------------------------------------------------------------
    // each flag moves only on its own event or a flag-register write, brown-out also on power-on; others hold
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_flag
            if (i == `RC_BIT_UNUSED) begin : g_none
                assign flags[i] = 1'b0;
            end else begin : g_bit
                reset_flag_bit #(
                    .RESET_VAL(POR_FLAGS[i]),
                    .EVT_VAL(i >= `RC_BIT_STK_UNDER)
                ) u_bit (
                    .clk_i(clk_i),
                    .sys_rst_i(sys_rst_i),
                    .evt_i(evt_eff[i]),
                    .wr_i(wr_flags),
                    .wdata_i(hwdata_i[i]),
                    .flag_o(flags[i])
                );
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // event status and mask
    // ------------------------------------------------------------------------
    assign evt_vec = evt_eff & `RC_FLAGS_IMPL;
    // set wins over a write-one clear
    assign next_status = evt_vec | (evt_status & ~(wr_status ? hwdata_i[7:0] : `RC_EVT_NONE));

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_status <= `RC_EVT_NONE;
            evt_mask <= `RC_EVT_NONE;
            irq_o <= 1'b0;
        end else begin
            evt_status <= next_status;
            evt_mask <= wr_mask ? (hwdata_i[7:0] & `RC_FLAGS_IMPL) : evt_mask;
            irq_o <= |(next_status & (wr_mask ? hwdata_i[7:0] : evt_mask));
        end
    end

    // ------------------------------------------------------------------------
    // read path: zero-wait, unmapped reads zero
    // ------------------------------------------------------------------------
    assign rd_mux = (hit_ofs == `RC_OFS_FLAGS) ? flags :
                    (hit_ofs == `RC_OFS_EVT_STATUS) ? evt_status :
                    (hit_ofs == `RC_OFS_EVT_MASK) ? evt_mask : `RC_EVT_NONE;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hrdata_o <= take_rd ? {24'h00_0000, rd_mux} : hrdata_o;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

endmodule // reset_cause_flags

// >>> sim/reset_cause_flags_chk.sv
// port checker for the reset-cause flag register
// assumes it is bound onto reset_cause_flags, one clock domain
`timescale 1ns/1ps
module reset_cause_flags_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire reset_cause_pkg::reset_evt_t evt_i,
    input wire logic [31:0] hrdata_o
);
    // ----------------------------------------
    // flag readback after a reset-source event
    // ----------------------------------------
    // address phase of a read of the flag register
    wire rd_flags = hsel_i && hready_i && htrans_i == 2'h2 && !hwrite_i && haddr_i[7:0] == 8'h00;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // event, then a flag read in the next cycle
    sequence ev_rd(e);
        e ##1 rd_flags;
    endsequence
    over_sets_a: assert property (ev_rd(evt_i.stk_over) |=> hrdata_o[7])
        else $error("overflow flag not set");
    under_sets_a: assert property (ev_rd(evt_i.stk_under) |=> hrdata_o[6])
        else $error("underflow flag not set");
    wdog_clears_a: assert property (ev_rd(evt_i.wdog) |=> !hrdata_o[4])
        else $error("watchdog flag not cleared");
    pin_clears_a: assert property (ev_rd(evt_i.pin) |=> !hrdata_o[3])
        else $error("pin flag not cleared");
    instr_clears_a: assert property (ev_rd(evt_i.instr) |=> !hrdata_o[2])
        else $error("instruction flag not cleared");
    poweron_clears_a: assert property (ev_rd(evt_i.poweron) |=> hrdata_o[1:0] == 2'h0)
        else $error("power-on flags not cleared");
    brownout_clears_a: assert property (ev_rd(evt_i.brownout) |=> !hrdata_o[0])
        else $error("brown-out flag not cleared");
    bit_five_a: assert property (rd_flags |=> hrdata_o[7:5] != 3'h7 && !hrdata_o[5])
        else $error("unused flag bit reads one");
endmodule // reset_cause_flags_chk

bind reset_cause_flags reset_cause_flags_chk u_chk (.clk_i, .sys_rst_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .evt_i, .hrdata_o);

// >>> sim/reset_cause_flags_test.sv
// self-checking bench for the reset-cause flag register
// assumes the design files and the constants header are compiled first
`timescale 1ns/1ps
`include "reset_cause_regs.svh"
module reset_cause_flags_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    reset_cause_pkg::reset_evt_t evt_i = 8'h00;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic irq_o;
    wire hready_i = hreadyout_o;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] rd;

    // ----------------------------------------
    // clock, design and helpers
    // ----------------------------------------
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    reset_cause_flags u_dut (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i, .evt_i, .hrdata_o, .hreadyout_o, .hresp_o, .irq_o);

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        hwrite_i <= wr;
        htrans_i <= `RC_HTRANS_NONSEQ;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
    endtask

    // one-cycle reset-source pulse
    task automatic pulse(input logic [7:0] e);
        evt_i <= reset_cause_pkg::reset_evt_t'(e);
        @(posedge clk_i);
        evt_i <= 8'h00;
    endtask

    // irq level once status has settled
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        cmp_bit(irq_o, exp);
        @(posedge clk_i);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // power-up values, bit 5 writes, unmapped place
    task automatic t_reset;
        bus(1'b0, `RC_OFS_FLAGS, 32'h0);
        cmp_word(rd, 32'h1C);
        cmp_bit(hresp_o, 1'b0);
        cmp_bit(hreadyout_o, 1'b1);
        bus(1'b1, `RC_OFS_FLAGS, 32'hFF);
        bus(1'b0, `RC_OFS_FLAGS, 32'h0);
        cmp_word(rd, 32'hDF);
        bus(1'b0, 8'h0C, 32'h0);
        cmp_word(rd, 32'h0);
        bus(1'b0, `RC_OFS_EVT_STATUS, 32'h0);
        cmp_word(rd, 32'h0);
    endtask

    // each source alone; the other flags keep their values, except brown-out on a power-on pulse
    task automatic t_sources;
        logic [7:0] base;
        logic [7:0] exp;
        for (int k = 0; k < 8; k++) begin
            base = (k > 5) ? 8'h00 : 8'hFF;
            exp = base & 8'hDF;
            if (k != `RC_BIT_UNUSED) exp[k] = (k > 5);
            if (k == 1) exp[0] = 1'b0;
            bus(1'b1, `RC_OFS_FLAGS, {24'h0, base});
            pulse(8'h01 << k);
            bus(1'b0, `RC_OFS_FLAGS, 32'h0);
            cmp_word(rd, {24'h0, exp});
        end
    endtask

    // sticky status, write-one-clear, mask and interrupt level
    task automatic t_irq;
        bus(1'b0, `RC_OFS_EVT_STATUS, 32'h0);
        cmp_word(rd, 32'hDF);
        bus(1'b1, `RC_OFS_EVT_STATUS, 32'hFF);
        bus(1'b0, `RC_OFS_EVT_STATUS, 32'h0);
        cmp_word(rd, 32'h0);
        bus(1'b1, `RC_OFS_EVT_MASK, 32'h10);
        bus(1'b0, `RC_OFS_EVT_MASK, 32'h0);
        cmp_word(rd, 32'h10);
        pulse(8'h01);
        chk_irq(1'b0);
        pulse(8'h10);
        chk_irq(1'b1);
        bus(1'b1, `RC_OFS_EVT_STATUS, 32'h10);
        chk_irq(1'b0);
        bus(1'b0, `RC_OFS_EVT_STATUS, 32'h0);
        cmp_word(rd, 32'h01);
    endtask

    // a second power-up mid-run restores the power-up values
    task automatic t_again;
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        cmp_bit(irq_o, 1'b0);
        bus(1'b0, `RC_OFS_FLAGS, 32'h0);
        cmp_word(rd, 32'h1C);
        bus(1'b0, `RC_OFS_EVT_MASK, 32'h0);
        cmp_word(rd, 32'h0);
    endtask

    task automatic complete_run;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // reset for 5 cycles, then the scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_sources;
        t_irq;
        t_again;
        complete_run;
    end

    // watchdog against a hung transfer
    initial begin
        repeat (2000) @(posedge clk_i);
        num_errors++;
        complete_run;
    end
endmodule // reset_cause_flags_test
